// >>> seh_sequencer.sv
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "seh_map.svh"

// Word buffer between the link and the bus
module seh_fifo
  import seh_pkg::*;
#(
  parameter int WIDTH = 14,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } seh_fifo_st_t;
  seh_fifo_st_t fifo_ff;
  seh_fifo_st_t nxt_fifo;
  logic         push;
  logic         pop;
  // Full and empty straight from the occupancy count
  assign in_ready  = fifo_ff.cnt != (AW+1)'(DEPTH);
  assign out_valid = fifo_ff.cnt != '0;
  assign out_data  = fifo_ff.mem[fifo_ff.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  // Pointers wrap naturally, so depth must be a power of two
  always_comb begin
    nxt_fifo = fifo_ff;
    if (push) begin
      nxt_fifo.mem[fifo_ff.wr] = in_data;
      nxt_fifo.wr              = AW'(fifo_ff.wr + 1'b1);
    end
    if (pop) begin
      nxt_fifo.rd = AW'(fifo_ff.rd + 1'b1);
    end
    nxt_fifo.cnt = (AW+1)'(fifo_ff.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fifo_ff <= '0;
    end else begin
      fifo_ff <= nxt_fifo;
    end
  end
endmodule

// Functional notes
// - Memory holds 100 words of 14 bits; each word erased and rewritten alone
// - Address goes out as 20 bits: tens one-of-ten code, then units code
// - Five lines: clock, three mode lines, one shared data line
// - Lines are inverted: logic zero is high level, logic one low level
// - Erase sets word to ones; write only follows an erase
// - After every read or write the memory returns to standby
module seh_sequencer
  import seh_pkg::*;
#(
  parameter int HALF_CYC   = `SEH_HALF_CYC,
  parameter int HOLD_CLKS  = `SEH_HOLD_CLKS,
  parameter int FIFO_DEPTH = `SEH_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Memory link
  output seh_link_t        link_o,
  input  wire logic        memory_serial_line_i
);
  localparam int DW = $clog2(HALF_CYC);
  localparam int WB = `SEH_WORD_BITS;

  typedef struct packed {
    seh_state_t    st;
    logic [DW-1:0] div;
    logic [7:0]    bits;
    logic [19:0]   asr;
    logic [WB-1:0] dsr;
    logic [7:0]    decimal_word_address;
    logic [WB-1:0] wdata;
    logic          op_write;
    logic          err;
    logic [1:0]    sync;
    seh_link_t     link;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          pop_ok;
  } seh_st_t;

  seh_st_t       st_ff;
  seh_st_t       nxt_st;
  logic          tick;
  logic          fall;
  logic          setup;
  logic          access;
  logic          mapped;
  logic [31:0]   rd_mux;
  logic          fifo_push;
  logic [WB-1:0] fifo_push_data;
  logic          fifo_in_ready;
  logic          fifo_out_valid;
  logic          fifo_out_ready;
  logic [WB-1:0] fifo_out_data;
  logic [WB-1:0] rx_word;
  logic [2:0]    mode_now;
  logic          bad_start;

  assign prdata  = st_ff.prdata;
  assign pready  = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign link_o  = st_ff.link;

  // Half period of the link clock elapsed
  assign tick   = st_ff.div == DW'(HALF_CYC - 1);
  assign fall   = tick && st_ff.link.memory_link_clock;
  assign setup  = psel && !penable;
  assign access = psel && penable && st_ff.pready;
  assign mapped = paddr inside {`SEH_OFF_CTRL, `SEH_OFF_ADDR, `SEH_OFF_WDATA,
                                `SEH_OFF_RDATA, `SEH_OFF_STATUS, `SEH_OFF_PORT};
  assign rx_word        = {~st_ff.sync[1], st_ff.dsr[WB-1:1]};  // Low level is a one
  assign fifo_out_ready = access && !pwrite && (paddr == `SEH_OFF_RDATA) && st_ff.pop_ok;
  // One-of-ten code of a decimal digit
  function automatic logic [9:0] one_of_ten(input logic [3:0] d);
    one_of_ten = 10'(10'h001 << d);
  endfunction
  // Logic mode code driven in each state
  always_comb begin
    unique case (st_ff.st)
      SEH_ADDR:  mode_now = SEH_M_ADDR;
      SEH_READ:  mode_now = SEH_M_READ;
      SEH_SHOUT: mode_now = SEH_M_SHOUT;
      SEH_ERASE: mode_now = SEH_M_ERASE;
      SEH_ACC:   mode_now = SEH_M_ACC;
      SEH_WRITE: mode_now = SEH_M_WRITE;
      default:   mode_now = SEH_M_STANDBY;
    endcase
  end
  // Register read mux
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      `SEH_OFF_ADDR:   rd_mux[7:0] = st_ff.decimal_word_address;
      `SEH_OFF_WDATA:  rd_mux[WB-1:0] = st_ff.wdata;
      `SEH_OFF_RDATA: begin
        rd_mux[WB-1:0]            = fifo_out_data;
        rd_mux[`SEH_RDATA_VALID]  = fifo_out_valid;
      end
      `SEH_OFF_STATUS: begin
        rd_mux[`SEH_STAT_BUSY]   = st_ff.st != SEH_IDLE;
        rd_mux[`SEH_STAT_ERR]    = st_ff.err;
        rd_mux[`SEH_STAT_RVALID] = fifo_out_valid;
        rd_mux[`SEH_STAT_ROOM]   = fifo_in_ready;
      end
      `SEH_OFF_PORT: begin
        rd_mux[`SEH_PORT_CLK] = st_ff.link.memory_link_clock;
        rd_mux[3:1]           = {st_ff.link.mode_line_three, st_ff.link.mode_line_direction,
                                 st_ff.link.mode_line_one};
        rd_mux[`SEH_PORT_DATA] = st_ff.link.memory_serial_line_oe ?
                                 st_ff.link.memory_serial_line_o : st_ff.sync[1];
      end
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  // Digits above nine, or a full buffer on a read start, refuse the start
  assign bad_start = (st_ff.decimal_word_address[7:4] > 4'h9) ||
                     (st_ff.decimal_word_address[3:0] > 4'h9) ||
                     (!pwdata[`SEH_CTRL_WRITE] && !fifo_in_ready);

  // Whole next state
  always_comb begin
    nxt_st         = st_ff;
    fifo_push      = 1'b0;
    fifo_push_data = rx_word;
    nxt_st.sync    = {st_ff.sync[0], memory_serial_line_i};
    // Zero-wait APB answer, data latched in the setup cycle
    nxt_st.pready  = setup;
    nxt_st.pslverr = setup && !mapped;
    nxt_st.prdata  = (setup && !pwrite) ? rd_mux : 32'h0000_0000;
    nxt_st.pop_ok  = setup && !pwrite && (paddr == `SEH_OFF_RDATA) && fifo_out_valid;
    if (access && pwrite) begin
      unique case (paddr)
        `SEH_OFF_ADDR:  nxt_st.decimal_word_address = pwdata[7:0];
        `SEH_OFF_WDATA: nxt_st.wdata = pwdata[WB-1:0];
        `SEH_OFF_CTRL: begin
          if (pwdata[`SEH_CTRL_ERRCLR]) begin
            nxt_st.err = 1'b0;
          end
          // Starts only from idle; a refused start wins over the clear
          if (st_ff.st == SEH_IDLE && (pwdata[`SEH_CTRL_READ] || pwdata[`SEH_CTRL_WRITE])) begin
            if (bad_start) begin
              nxt_st.err = 1'b1;
            end else begin
              nxt_st.st       = SEH_ADDR;
              nxt_st.bits     = 8'(`SEH_ADDR_BITS);
              nxt_st.asr      = {one_of_ten(st_ff.decimal_word_address[3:0]),
                                 one_of_ten(st_ff.decimal_word_address[7:4])};
              nxt_st.op_write = pwdata[`SEH_CTRL_WRITE];
              nxt_st.div      = '0;
              nxt_st.link.memory_link_clock = 1'b0;
            end
          end
        end
        default: ;
      endcase
    end
    // Link sequencer; the clock toggles on every tick while busy
    if (st_ff.st != SEH_IDLE) begin
      nxt_st.div = tick ? '0 : DW'(st_ff.div + 1'b1);
      if (tick && !st_ff.link.memory_link_clock && st_ff.bits == 8'd0) begin
        // Last bit ended on a fall; only now rise into standby
        nxt_st.st   = SEH_IDLE;
        nxt_st.link = seh_link_t'(`SEH_LINK_RST);
      end else if (tick && !st_ff.link.memory_link_clock) begin
        // Rising: new mode and data bit while the clock is high
        nxt_st.link.memory_link_clock = 1'b1;
        {nxt_st.link.mode_line_one, nxt_st.link.mode_line_direction,
         nxt_st.link.mode_line_three} = ~mode_now;
        nxt_st.link.memory_serial_line_oe = st_ff.st != SEH_SHOUT;
        unique case (st_ff.st)
          SEH_ADDR: nxt_st.link.memory_serial_line_o = ~st_ff.asr[0];
          SEH_ACC:  nxt_st.link.memory_serial_line_o = ~st_ff.dsr[0];
          default:  nxt_st.link.memory_serial_line_o = 1'b1;
        endcase
      end else if (fall) begin
        // Falling: sample, shift and count the bit
        nxt_st.link.memory_link_clock = 1'b0;
        nxt_st.bits = 8'(st_ff.bits - 8'd1);
        if (st_ff.st == SEH_ADDR) begin
          nxt_st.asr = {1'b0, st_ff.asr[19:1]};
        end
        if (st_ff.st == SEH_ACC) begin
          nxt_st.dsr = {1'b0, st_ff.dsr[WB-1:1]};
        end
        if (st_ff.st == SEH_SHOUT) begin
          nxt_st.dsr = rx_word;
        end
        if (st_ff.bits == 8'd1) begin
          unique case (st_ff.st)
            SEH_ADDR: begin
              nxt_st.st   = st_ff.op_write ? SEH_ERASE : SEH_READ;
              nxt_st.bits = st_ff.op_write ? 8'(HOLD_CLKS) : 8'(`SEH_READ_CLKS);
            end
            SEH_READ: begin
              nxt_st.st   = SEH_SHOUT;
              nxt_st.bits = 8'(WB);
            end
            SEH_ERASE: begin
              nxt_st.st   = SEH_ACC;
              nxt_st.bits = 8'(WB);
              nxt_st.dsr  = st_ff.wdata;
            end
            SEH_ACC: begin
              nxt_st.st   = SEH_WRITE;
              nxt_st.bits = 8'(HOLD_CLKS);
            end
            default: begin
              // Shift-out or write done: push the word after a shift-out only; the bit still ends low
              fifo_push = st_ff.st == SEH_SHOUT;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_ff <= '{st: SEH_IDLE, decimal_word_address: `SEH_ADDR_RST, wdata: `SEH_WDATA_RST,
                 link: seh_link_t'(`SEH_LINK_RST), default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Read words wait here; a full buffer refuses new reads
  seh_fifo #(.WIDTH (WB), .DEPTH (FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_push_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_start;
    st_ff.st == SEH_IDLE ##1 st_ff.st == SEH_ADDR;
  endsequence
  sequence s_finish;
    st_ff.st != SEH_IDLE ##1 st_ff.st == SEH_IDLE;
  endsequence
  property p_range;
    s_start |-> $past(st_ff.decimal_word_address[7:4]) <= 4'h9 &&
                $past(st_ff.decimal_word_address[3:0]) <= 4'h9;
  endproperty
  a_range: assert property (p_range) else $error("start with digit above nine");
  property p_addr20;
    s_start |-> st_ff.bits == 8'd20 && $countones(st_ff.asr) == 2;
  endproperty
  a_addr20: assert property (p_addr20) else $error("address frame not 20 bits");
  property p_standby;
    s_finish |-> st_ff.link == seh_link_t'(`SEH_LINK_RST);
  endproperty
  a_standby: assert property (p_standby) else $error("no standby after operation");
  property p_erase_first;
    st_ff.st == SEH_ACC && $past(st_ff.st) != SEH_ACC |-> $past(st_ff.st) == SEH_ERASE;
  endproperty
  a_erase_first: assert property (p_erase_first) else $error("data before erase");
  property p_release;
    st_ff.st == SEH_SHOUT && st_ff.link.memory_link_clock |-> !st_ff.link.memory_serial_line_oe;
  endproperty
  a_release: assert property (p_release) else $error("data line held while receiving");
  property p_invert;
    st_ff.st == SEH_ADDR && st_ff.link.memory_link_clock
      |-> st_ff.link.memory_serial_line_o == !st_ff.asr[0] && !st_ff.link.mode_line_direction;
  endproperty
  a_invert: assert property (p_invert) else $error("address level not inverted");
  property p_steady_clock;
    st_ff.st != SEH_IDLE && !tick |=> $stable(st_ff.link.memory_link_clock);
  endproperty
  a_steady_clock: assert property (p_steady_clock) else $error("link clock edge off tick");
  property p_read1;
    st_ff.st == SEH_READ && fall && st_ff.bits == 8'd1
      |=> st_ff.st == SEH_SHOUT && st_ff.bits == 8'd14;
  endproperty
  a_read1: assert property (p_read1) else $error("read not one clock then 14");
endmodule

// >>> seh_map.svh
`ifndef SEH_MAP_SVH
`define SEH_MAP_SVH

// Register byte offsets on the APB bus
`define SEH_OFF_CTRL       8'h00
`define SEH_OFF_ADDR       8'h04
`define SEH_OFF_WDATA      8'h08
`define SEH_OFF_RDATA      8'h0c
`define SEH_OFF_STATUS     8'h10
`define SEH_OFF_PORT       8'h14

// Control register fields
`define SEH_CTRL_READ      0
`define SEH_CTRL_WRITE     1
`define SEH_CTRL_ERRCLR    2

// Status register fields
`define SEH_STAT_BUSY      0
`define SEH_STAT_ERR       1
`define SEH_STAT_RVALID    2
`define SEH_STAT_ROOM      3

// Read data field: fifo head valid flag
`define SEH_RDATA_VALID    31

// Port image fields
`define SEH_PORT_CLK       0
`define SEH_PORT_DATA      4

// Reset values
`define SEH_ADDR_RST       8'h00
`define SEH_WDATA_RST      14'h0000
`define SEH_LINK_RST       6'h3f

// Link framing counts and read buffer depth
`define SEH_ADDR_BITS      20
`define SEH_WORD_BITS      14
`define SEH_READ_CLKS      1
`define SEH_FIFO_DEPTH     32

// Timing: host clock, link half period, erase and write hold
`define SEH_CLK_NS         5
`define SEH_HALF_US        36
`define SEH_HALF_CYC       ((`SEH_HALF_US * 1000) / `SEH_CLK_NS)
`define SEH_HOLD_US        18000
`define SEH_HOLD_CLKS      ((`SEH_HOLD_US + 2 * `SEH_HALF_US - 1) / (2 * `SEH_HALF_US))

`endif

// >>> seh_pkg.sv
package seh_pkg;

  // Sequencer states, one-hot
  typedef enum logic [6:0] {
    SEH_IDLE  = 7'h01,
    SEH_ADDR  = 7'h02,
    SEH_READ  = 7'h04,
    SEH_SHOUT = 7'h08,
    SEH_ERASE = 7'h10,
    SEH_ACC   = 7'h20,
    SEH_WRITE = 7'h40
  } seh_state_t;

  // Memory mode codes as logic levels {one, direction, three}
  typedef enum logic [2:0] {
    SEH_M_STANDBY = 3'h0,
    SEH_M_ADDR    = 3'h3,
    SEH_M_READ    = 3'h4,
    SEH_M_SHOUT   = 3'h5,
    SEH_M_ERASE   = 3'h2,
    SEH_M_ACC     = 3'h7,
    SEH_M_WRITE   = 3'h6
  } seh_mode_t;

  // Link pins as voltage levels
  typedef struct packed {
    logic memory_link_clock;
    logic mode_line_one;
    logic mode_line_direction;
    logic mode_line_three;
    logic memory_serial_line_o;
    logic memory_serial_line_oe;
  } seh_link_t;

endpackage

// >>> seh_mem_model.sv
`timescale 1ns/1ps

// Behavioural serial memory on the far side of the link
module seh_mem_model (
  // Link pins as voltage levels
  input  wire logic       lclk,
  input  wire logic [2:0] mode_lvl,
  input  wire logic       line_lvl,
  // Drive of the shared data line
  output logic            mem_o,
  output logic            mem_oe
);
  logic [13:0] mem_q [0:99] = '{default: 14'h1555};
  logic        erased [0:99] = '{default: 1'b0};
  logic [19:0] addr_sr = 20'h0;
  logic [13:0] data_sr = 14'h0;
  logic [2:0]  mode_q = 3'h0;
  logic [2:0]  prev;
  logic        bit_q;
  int          cnt [0:7] = '{default: 0};
  int          bad_write = 0;
  int          bad_seq = 0;
  int          idx;

  initial begin
    mem_o = 1'b1;
    mem_oe = 1'b0;
  end

  // One-of-ten code to digit; a malformed code gives 10
  function automatic int digit(input logic [9:0] c);
    int d;
    d = 10;
    for (int i = 0; i < 10; i++) begin
      if (c == (10'h001 << i)) begin
        d = i;
      end
    end
    return d;
  endfunction

  // Mode and bit change with the rise, so sample them once settled
  always @(posedge lclk) begin
    #1;
    prev = mode_q;
    mode_q = ~mode_lvl;
    bit_q = ~line_lvl;
    if (prev == 3'h0 && mode_q == 3'h3) begin
      cnt = '{default: 0};
    end
    // Modes may only follow the read order or the write order
    if (mode_q != prev &&
        !({prev, mode_q} inside {6'h03, 6'h1c, 6'h25, 6'h28, 6'h1a, 6'h17, 6'h3e, 6'h30})) begin
      bad_seq++;
    end
    mem_oe = (mode_q == 3'h5);
    mem_o = ~data_sr[0];
  end

  // Each fall completes one bit in the mode latched at the rise
  always @(negedge lclk) begin
    idx = digit(addr_sr[9:0]) * 10 + digit(addr_sr[19:10]);
    if (mode_q != 3'h0) begin
      cnt[mode_q] = cnt[mode_q] + 1;
    end
    case (mode_q)
      3'h3: addr_sr = {bit_q, addr_sr[19:1]};
      3'h4: data_sr = mem_q[idx];
      3'h5: begin
        data_sr = data_sr >> 1;
        mem_oe = (cnt[5] < 14);
      end
      3'h2: begin
        mem_q[idx] = 14'h3fff;
        erased[idx] = 1'b1;
      end
      3'h7: data_sr = {bit_q, data_sr[13:1]};
      3'h6: begin
        bad_write += int'(!erased[idx]);
        mem_q[idx] = data_sr;
      end
      default: ;
    endcase
  end
endmodule

// >>> seh_sequencer_tb_top.sv
`timescale 1ns/1ps
`include "seh_map.svh"

`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end

// Bench for the serial memory host sequencer
module seh_sequencer_tb_top;
  import seh_pkg::*;
  localparam int HALF = 4;
  localparam int HOLD = 3;
  logic        clk_sys = 1'b0;
  logic        rst;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  seh_link_t   link_o;
  logic        mem_o;
  logic        mem_oe;
  logic        line_lvl;
  logic [31:0] rd;
  logic        err;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          clash = 0;
  int          gap = 0;
  int          link_err = 0;
  logic        lclk_q = 1'b1;
  logic        line_q = 1'b1;
  logic        frame;

  // A frame is any time the mode lines are off standby
  assign frame = !(&{link_o.mode_line_one, link_o.mode_line_direction, link_o.mode_line_three});

  // Pull-up wins when neither side drives the shared line
  assign line_lvl = link_o.memory_serial_line_oe ? link_o.memory_serial_line_o :
                    (mem_oe ? mem_o : 1'b1);

  seh_sequencer #(.HALF_CYC(HALF), .HOLD_CLKS(HOLD), .FIFO_DEPTH(32)) seh_sequencer_inst (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_o(link_o), .memory_serial_line_i(line_lvl));

  seh_mem_model seh_mem_model_inst (
    .lclk(link_o.memory_link_clock),
    .mode_lvl({link_o.mode_line_one, link_o.mode_line_direction, link_o.mode_line_three}),
    .line_lvl(line_lvl), .mem_o(mem_o), .mem_oe(mem_oe));

  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Both ends driving at once would fight; memory drives only toward the host
  always @(posedge clk_sys) begin
    if (mem_oe && (link_o.memory_serial_line_oe || !link_o.mode_line_direction)) begin
      clash <= clash + 1;
    end
  end

  // In a frame the clock toggles every HALF cycles and data moves only as it rises
  always @(posedge clk_sys) begin
    lclk_q <= link_o.memory_link_clock;
    line_q <= link_o.memory_serial_line_o;
    gap    <= (link_o.memory_link_clock != lclk_q) ? 1 : gap + 1;
    if (frame && ((link_o.memory_link_clock != lclk_q && gap != HALF) ||
                  (link_o.memory_serial_line_o != line_q && !link_o.memory_link_clock))) begin
      link_err <= link_err + 1;
    end
  end

  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic bound(input logic done);
    if (done !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] wait expected done seen timeout");
      tally_and_finish();
    end
  endtask

  // One APB transfer; pready, read data and error are taken at one rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    bound(pready === 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Start an operation and poll until busy drops
  task automatic run_op(input logic [31:0] ctrl);
    int n;
    apb(1'b1, `SEH_OFF_CTRL, ctrl);
    n = 0;
    do begin
      apb(1'b0, `SEH_OFF_STATUS, 32'h0);
      n++;
    end while (rd[`SEH_STAT_BUSY] !== 1'b0 && n < 1000);
    bound(rd[`SEH_STAT_BUSY] === 1'b0);
  endtask

  // Reset values, idle port image and an unmapped access
  task automatic t_reset;
    `CHK("link idle", 6'h3f, link_o);
    apb(1'b0, `SEH_OFF_ADDR, 32'h0);
    `CHK("addr reg", 32'h0, rd);
    apb(1'b0, `SEH_OFF_WDATA, 32'h0);
    `CHK("wdata reg", 32'h0, rd);
    apb(1'b0, `SEH_OFF_STATUS, 32'h0);
    `CHK("status", 32'h8, rd);
    apb(1'b0, `SEH_OFF_PORT, 32'h0);
    `CHK("port", 32'h1f, rd);
    apb(1'b0, 8'h18, 32'h0);
    `CHK("slverr", 1'b1, err);
    `CHK("unmapped", 32'h0, rd);
  endtask

  // Full write then read back of one word
  task automatic t_word(input logic [7:0] a, input logic [13:0] w);
    int i;
    i = a[7:4] * 10 + a[3:0];
    apb(1'b1, `SEH_OFF_ADDR, {24'h0, a});
    apb(1'b1, `SEH_OFF_WDATA, {18'h0, w});
    run_op(32'h2);
    `CHK("stored", w, seh_mem_model_inst.mem_q[i]);
    `CHK("addr clks", 20, seh_mem_model_inst.cnt[3]);
    `CHK("erase clks", HOLD, seh_mem_model_inst.cnt[2]);
    `CHK("data clks", 14, seh_mem_model_inst.cnt[7]);
    `CHK("write clks", HOLD, seh_mem_model_inst.cnt[6]);
    `CHK("bad write", 0, seh_mem_model_inst.bad_write);
    `CHK("standby w", 6'h3f, link_o);
    run_op(32'h1);
    `CHK("raddr clks", 20, seh_mem_model_inst.cnt[3]);
    `CHK("read clks", 1, seh_mem_model_inst.cnt[4]);
    `CHK("shout clks", 14, seh_mem_model_inst.cnt[5]);
    `CHK("standby r", 6'h3f, link_o);
    `CHK("clash", 0, clash);
    `CHK("link timing", 0, link_err);
    `CHK("mode order", 0, seh_mem_model_inst.bad_seq);
    apb(1'b0, `SEH_OFF_RDATA, 32'h0);
    `CHK("rdata", {1'b1, 17'h0, w}, rd);
  endtask

  // Malformed digits refuse to start; error then clears
  task automatic t_refuse(input logic [7:0] a);
    apb(1'b1, `SEH_OFF_ADDR, {24'h0, a});
    run_op(32'h1);
    apb(1'b0, `SEH_OFF_STATUS, 32'h0);
    `CHK("err set", 32'ha, rd);
    apb(1'b1, `SEH_OFF_CTRL, 32'h4);
    apb(1'b0, `SEH_OFF_STATUS, 32'h0);
    `CHK("err clear", 32'h8, rd);
  endtask

  // Fill the buffer until it refuses, then drain it empty
  task automatic t_fifo;
    apb(1'b1, `SEH_OFF_ADDR, 32'h23);
    for (int k = 0; k < 32; k++) run_op(32'h1);
    apb(1'b0, `SEH_OFF_STATUS, 32'h0);
    `CHK("full", 32'h4, rd);
    run_op(32'h1);
    apb(1'b0, `SEH_OFF_STATUS, 32'h0);
    `CHK("full err", 32'h6, rd);
    apb(1'b1, `SEH_OFF_CTRL, 32'h4);
    for (int k = 0; k < 32; k++) begin
      apb(1'b0, `SEH_OFF_RDATA, 32'h0);
      `CHK("drain", 32'h8000_2a5c, rd);
    end
    apb(1'b0, `SEH_OFF_RDATA, 32'h0);
    `CHK("empty", 1'b0, rd[31]);
    apb(1'b0, `SEH_OFF_STATUS, 32'h0);
    `CHK("empty st", 32'h8, rd);
  endtask

  // Main sequence
  initial begin
    rst <= 1'b1;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_word(8'h23, 14'h2a5c);
    t_word(8'h00, 14'h0001);
    t_word(8'h99, 14'h3fff);
    t_refuse(8'h3a);
    t_refuse(8'ha3);
    t_fifo();
    tally_and_finish();
  end
endmodule
